// file: msf_gate_drv_model.sv
// model of the three external gate driver chips sharing one enable line
// assumes the gate inputs are plain logic levels from the sequencer
`timescale 1ns/1ps
`default_nettype none
module msf_gate_drv_model (
    input wire logic [2:0] i_gate,
    input wire logic i_enable,
    output logic [2:0] o_high_on,
    output logic [2:0] o_low_on
);
    // ------------------------------------------------------------------
    // switch control
    // ------------------------------------------------------------------
    // enable low turns both switches of every phase off, so a faulted
    // module drops out instead of shorting the shared output
    assign o_high_on = i_enable ? i_gate : 3'h0;
    assign o_low_on = i_enable ? ~i_gate : 3'h0;
endmodule
`default_nettype wire

// file: msf_phase_osc.sv
// oscillator that marks the start of each phase's switching cycle
// assumes one core clock; starts are one-cycle pulses, a third apart
`timescale 1ns/1ps
`default_nettype none
module msf_phase_osc
    import msf_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    output logic [NUM_PHASES-1:0] o_start
);
    logic [OSC_CNT_W-1:0] cnt_reg;
    localparam logic [OSC_CNT_W-1:0] CNT_LAST = OSC_CNT_W'(OSC_PERIOD_CYC - 1);

    // ------------------------------------------------------------------
    // free-running cycle counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else if (cnt_reg == CNT_LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + OSC_CNT_W'(1);
        end
    end

    // staggered starts; a period of 50 cannot split evenly, so the
    // gap from the last phase back to the first is two cycles longer
    always_comb begin
        for (int k = 0; k < NUM_PHASES; k++) begin
            o_start[k] = (cnt_reg == phase_offset(k));  // [RQ8]
        end
    end
endmodule
`default_nettype wire

// file: msf_pkg.sv
// constants, types and helpers shared by the fault and soft-start sequencer
// assumes a single 20 MHz core clock; no other files are needed
`default_nettype none
package msf_pkg;
    // ------------------------------------------------------------------
    // clock and oscillator timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_PERIOD_NS = 2500;  // 400 kHz switching cycle
    localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int NUM_PHASES = 3;
    localparam int PHASE_STEP_CYC = OSC_PERIOD_CYC / NUM_PHASES;
    localparam int OSC_CNT_W = 6;

    // ------------------------------------------------------------------
    // register port and map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATE = 4'hc;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam int CTRL_FORCE_OFF = 0;
    localparam logic [4:0] VID_OFF_CODE = 5'h1f;

    // event bit positions in status and mask
    localparam int EV_MODULE_OC = 0;
    localparam int EV_PHASE_LIMIT = 1;
    localparam int EV_VID_OFF = 2;
    localparam int EV_ENABLE_LOW = 3;
    localparam int EV_SUPPLY_LOW = 4;
    localparam int EV_SOFTSTART_DONE = 5;
    localparam int EV_W = 6;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_DISCHARGE,
        ST_SOFTSTART,
        ST_RUN
    } msf_state_type;

    // comparator and pin results, all from the analog side
    typedef struct packed {
        logic [2:0] pwm_trip;
        logic [2:0] phase_limit;
        logic module_oc;
        logic supply_above_upper;
        logic supply_below_lower;
        logic comp_above_release;
        logic comp_below_low;
        logic [4:0] voltage_id_code;
        logic module_on_input;
        logic power_good_window_ok;
    } msf_sense_type;

    // counter value at which a phase's oscillator cycle begins
    function automatic logic [OSC_CNT_W-1:0] phase_offset(input int k);
        phase_offset = OSC_CNT_W'(k * PHASE_STEP_CYC);
    endfunction
endpackage
`default_nettype wire

// file: msf_sequencer.sv
// top of the fault and soft-start sequencer for a three-phase buck
// assumes comparator results arrive as levels on i_sense and that the
// register port follows a one-cycle strobe protocol with no wait states
//
// What this block does
// RQ1: phase current limit ends that phase's gate pulse for this cycle only
// RQ2: module overcurrent sets fault latch and selects the compensation sink
// RQ3: compensation below low threshold after overcurrent restarts soft start
// RQ4: soft start selects charge source and holds all gates low
// RQ5: release threshold lets gates switch; overcurrent returns to discharge
// RQ6: gates disabled until supply reaches upper, again below lower threshold
// RQ7: overcurrent stops switching, drops driver enable, drives share fault
// RQ8: each gate rises at its own cycle start, phases a third apart
// RQ9: all-ones voltage ID stops switching and drops driver enable
// RQ10: module-on low pulls power good and driver enable low
// RQ11: all comparator and pin inputs pass two synchroniser flops
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module msf_sequencer
    import msf_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire msf_sense_type i_sense,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rd_data,
    output logic [NUM_PHASES-1:0] o_gate,
    output logic o_driver_enable_out,
    output logic o_power_good_out,
    output logic o_power_good_oe,
    output logic o_comp_sink_sel,
    output logic o_comp_charge_sel,
    output logic o_share_fault_drive,
    output logic o_irq
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    msf_sense_type s;
    msf_state_type state_reg, state_next;
    logic [NUM_PHASES-1:0] start, gate_reg, gate_clear;
    logic supply_ok_reg, supply_ok_next;
    logic oc_latch_reg, pg_oe_reg, hold, vid_off, run_next;
    logic [EV_W-1:0] status_reg, mask_reg, ev, cond, cond_prev_reg;
    logic [DATA_W-1:0] ctrl_reg;
    logic soft_done;

    // power-up levels of the event conditions: leaving reset with the
    // supply still low, or before the enable pin has been seen through the
    // synchroniser, is not reported as a fall
    localparam logic [EV_W-1:0] COND_AT_RESET = EV_W'((1 << EV_ENABLE_LOW)
        | (1 << EV_SUPPLY_LOW));

    // ------------------------------------------------------------------
    // input synchronisation and oscillator
    // ------------------------------------------------------------------
    msf_sync #(.WIDTH($bits(msf_sense_type))) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_d(i_sense),
        .o_q(s)
    );

    msf_phase_osc u_osc (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .o_start(start)
    );

    // ------------------------------------------------------------------
    // supply lockout with hysteresis
    // ------------------------------------------------------------------
    // between the two thresholds the previous verdict stands
    always_comb begin
        supply_ok_next = supply_ok_reg;
        if (s.supply_below_lower) begin
            supply_ok_next = 1'b0;  // [RQ6]
        end else if (s.supply_above_upper) begin
            supply_ok_next = 1'b1;  // [RQ6]
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            supply_ok_reg <= 1'b0;
        end else begin
            supply_ok_reg <= supply_ok_next;
        end
    end

    // ------------------------------------------------------------------
    // fault and soft-start state machine
    // ------------------------------------------------------------------
    assign vid_off = (s.voltage_id_code == VID_OFF_CODE);
    // conditions that keep the converter parked in discharge
    assign hold = vid_off | ~s.module_on_input | ctrl_reg[CTRL_FORCE_OFF]
        | ~supply_ok_next;  // [RQ6] [RQ9] [RQ10]

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_DISCHARGE: begin
                if (s.comp_below_low && !hold) begin
                    state_next = ST_SOFTSTART;  // [RQ3]
                end
            end
            ST_SOFTSTART: begin
                if (hold || s.module_oc) begin
                    state_next = ST_DISCHARGE;
                end else if (s.comp_above_release) begin
                    state_next = ST_RUN;  // [RQ5]
                end
            end
            ST_RUN: begin
                if (hold || s.module_oc) begin
                    state_next = ST_DISCHARGE;  // [RQ5] [RQ7]
                end
            end
            default: begin
                state_next = ST_DISCHARGE;  // a fourth code is illegal
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_DISCHARGE;
        end else begin
            state_reg <= state_next;
        end
    end

    // module overcurrent latch, cleared once the node is discharged
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            oc_latch_reg <= 1'b0;
        end else if (s.module_oc && state_reg != ST_DISCHARGE) begin
            oc_latch_reg <= 1'b1;  // [RQ2]
        end else if (s.comp_below_low) begin
            oc_latch_reg <= 1'b0;  // [RQ7]
        end
    end

    // every fault mode sinks the node; only soft start charges it
    assign o_comp_sink_sel = (state_reg == ST_DISCHARGE);  // [RQ2]
    assign o_comp_charge_sel = (state_reg == ST_SOFTSTART);  // [RQ4]
    assign o_driver_enable_out = (state_reg != ST_DISCHARGE);  // [RQ7]
    assign o_share_fault_drive = oc_latch_reg;  // [RQ7]

    // ------------------------------------------------------------------
    // gate outputs
    // ------------------------------------------------------------------
    // the clear looks at the next state so gates leave with the state
    assign run_next = (state_next == ST_RUN);
    assign gate_clear = s.pwm_trip | s.phase_limit  // [RQ1]
        | {NUM_PHASES{~run_next}};  // [RQ4] [RQ6] [RQ9]

    // clear wins over start: a limit still high at the cycle start
    // yields no pulse rather than a runt
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            gate_reg <= '0;
        end else begin
            gate_reg <= (gate_reg | start) & ~gate_clear;  // [RQ1] [RQ8]
        end
    end
    assign o_gate = gate_reg;

    // ------------------------------------------------------------------
    // power good pin (open drain, only ever pulls low)
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pg_oe_reg <= 1'b1;
        end else begin
            pg_oe_reg <= ~s.module_on_input  // [RQ10]
                | ~s.power_good_window_ok;
        end
    end
    assign o_power_good_oe = pg_oe_reg;
    assign o_power_good_out = 1'b0;

    // ------------------------------------------------------------------
    // events, status, mask and interrupt
    // ------------------------------------------------------------------
    // events are rising edges of these conditions; a level that stays set
    // raises no second event until it has gone away once
    assign soft_done = (state_reg == ST_SOFTSTART) && (state_next == ST_RUN);
    always_comb begin
        cond = '0;
        cond[EV_MODULE_OC] = oc_latch_reg;
        cond[EV_PHASE_LIMIT] = |s.phase_limit;
        cond[EV_VID_OFF] = vid_off;
        cond[EV_ENABLE_LOW] = ~s.module_on_input;
        cond[EV_SUPPLY_LOW] = ~supply_ok_reg;
        cond[EV_SOFTSTART_DONE] = soft_done;
    end
    assign ev = cond & ~cond_prev_reg;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cond_prev_reg <= COND_AT_RESET;
        end else begin
            cond_prev_reg <= cond;
        end
    end

    // write-one-to-clear; an event in the clearing cycle survives
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            status_reg <= '0;
        end else if (i_wr && i_addr == ADDR_STATUS) begin
            status_reg <= (status_reg & ~i_wr_data[EV_W-1:0]) | ev;
        end else begin
            status_reg <= status_reg | ev;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_reg <= MASK_RESET[EV_W-1:0];
            ctrl_reg <= DATA_ZERO;
        end else if (i_wr) begin
            if (i_addr == ADDR_MASK) begin
                mask_reg <= i_wr_data[EV_W-1:0];
            end
            if (i_addr == ADDR_CTRL) begin
                ctrl_reg <= i_wr_data;
            end
        end
    end
    assign o_irq = |(status_reg & mask_reg);

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= DATA_ZERO;
        end else if (!i_rd) begin
            o_rd_data <= DATA_ZERO;
        end else begin
            unique case (i_addr)
                ADDR_STATUS: o_rd_data <= DATA_W'(status_reg);
                ADDR_MASK: o_rd_data <= DATA_W'(mask_reg);
                ADDR_CTRL: o_rd_data <= ctrl_reg;
                ADDR_STATE: o_rd_data <= DATA_W'({o_driver_enable_out,
                    oc_latch_reg, supply_ok_reg, state_reg});
                default: o_rd_data <= DATA_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    a_limit_ends_pulse: assert property ( // [RQ1]
        |s.phase_limit |=> ((o_gate & $past(s.phase_limit)) == '0))
        else $error("gate stayed high past its phase limit");
    a_oc_selects_sink: assert property ( // [RQ2]
        (s.module_oc && state_reg == ST_RUN) |=>
        (o_comp_sink_sel && oc_latch_reg) until s.comp_below_low)
        else $error("overcurrent did not hold the sink");
    a_low_restarts_soft: assert property ( // [RQ3]
        (state_reg == ST_DISCHARGE && s.comp_below_low && !hold) |=>
        state_reg == ST_SOFTSTART && o_comp_charge_sel)
        else $error("discharged node did not restart soft start");
    a_soft_gates_low: assert property ( // [RQ4]
        (state_reg == ST_SOFTSTART) |-> (o_gate == '0))
        else $error("gate high during soft start");
    a_release_runs: assert property ( // [RQ5]
        (state_reg == ST_SOFTSTART && s.comp_above_release && !hold
        && !s.module_oc) |=> state_reg == ST_RUN)
        else $error("release threshold did not start switching");
    a_lockout_gates: assert property ( // [RQ6]
        s.supply_below_lower |=> !supply_ok_reg && o_gate == '0
        && !o_driver_enable_out)
        else $error("gates active below the lower supply threshold");
    a_oc_fault_drive: assert property ( // [RQ7]
        oc_latch_reg |-> o_share_fault_drive && !o_driver_enable_out
        && o_gate == '0)
        else $error("overcurrent fault left the drivers on");
    a_gate_rises_start: assert property ( // [RQ8]
        (start[1] && run_next && !gate_clear[1]) |=> o_gate[1])
        else $error("gate did not rise at its cycle start");
    a_vid_stops: assert property ( // [RQ9]
        vid_off |=> !o_driver_enable_out ##0 o_gate == '0)
        else $error("all-ones code did not stop switching");
    a_enable_low_off: assert property ( // [RQ10]
        !s.module_on_input |=> o_power_good_oe && !o_driver_enable_out)
        else $error("module off did not pull power good low");

    c_hiccup: cover property (
        state_reg == ST_RUN ##1 state_reg == ST_DISCHARGE
        ##[1:200] state_reg == ST_SOFTSTART);
    c_phase_limit: cover property (o_gate[0] ##1 !o_gate[0] && !start[0]);
    c_all_gates: cover property (o_gate == 3'h7);
    c_irq: cover property (o_irq);
    c_force_off: cover property (ctrl_reg[CTRL_FORCE_OFF] && o_comp_sink_sel);
endmodule
`default_nettype wire

// file: msf_sequencer_tb_top.sv
// self-checking bench for the fault and soft-start sequencer
// assumes the gate driver model is compiled before this file
`timescale 1ns/1ps
`default_nettype none
module msf_sequencer_tb_top
    import msf_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    msf_sense_type sense;
    msf_sense_type sense_w;
    logic [2:0] trip = 3'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] rdata;
    logic [2:0] gate, hi_on, lo_on;
    logic drv, pg_out, pg_oe, sink, chg, share, irq, pg_wire;
    logic [7:0] q_rd[$];
    logic [9:0] q_pin[$];
    int fail_count = 0;
    int num_checks = 0;
    int n, hi, k;

    // ------------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------------
    always #25 clk = ~clk;

    // a conducting high switch soon trips the pwm comparator
    always @(posedge clk) trip <= hi_on;
    always_comb begin
        sense_w = sense;
        sense_w.pwm_trip = trip;
    end
    assign pg_wire = pg_oe ? pg_out : 1'b1; // pulled up off chip

    msf_sequencer dut (
        .i_core_clk(clk), .i_rst(rst), .i_sense(sense_w), .i_addr(addr),
        .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata),
        .o_gate(gate), .o_driver_enable_out(drv), .o_power_good_out(pg_out),
        .o_power_good_oe(pg_oe), .o_comp_sink_sel(sink),
        .o_comp_charge_sel(chg), .o_share_fault_drive(share), .o_irq(irq)
    );
    msf_gate_drv_model drivers (
        .i_gate(gate), .i_enable(drv), .o_high_on(hi_on), .o_low_on(lo_on)
    );

    // ------------------------------------------------------------------
    // checking
    // ------------------------------------------------------------------
    task automatic cmp(input logic [9:0] exp, input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // notes are taken off at the falling edge, when outputs have settled
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        logic [9:0] e;
        logic [8:0] g;
        if (rd_d)
            cmp({2'h0, q_rd.pop_front()}, {2'h0, rdata});
        if (q_pin.size() > 0) begin
            e = q_pin.pop_front();
            g = {gate, drv, pg_wire, sink, chg, share, irq};
            if (e[9])
                g[8:6] = e[8:6];
            cmp({1'b0, e[8:0]}, {1'b0, g});
        end
    end

    // top bit set means the gates are switching and are not compared
    function automatic logic [9:0] ex(input logic r, dv, pg, sk, cg, sh, iq);
        return {r, 3'h0, dv, pg, sk, cg, sh, iq};
    endfunction

    // ------------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic chk(input logic [9:0] e);
        q_pin.push_back(e);
        @(posedge clk);
    endtask

    // a spare edge after each strobe keeps one assignment per time step
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
        q_rd.push_back(exp);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // count cycles in which any selected gate is high, looking at the
    // falling edge where the registered gates have settled
    task automatic no_gate(input logic [2:0] m);
        hi = 0;
        repeat (60) begin
            @(negedge clk);
            if ((gate & m) !== 3'h0)
                hi++;
        end
        @(posedge clk);
        cmp(10'h0, 10'(hi));
    endtask

    // the first look only primes the history, so a gate already high
    // is not taken as a rise; returns on a rising edge or after 200 looks
    task automatic wait_rise(input int p, output int cnt);
        logic was;
        was = 1'b1;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            if (was === 1'b0 && gate[p] === 1'b1)
                break;
            was = gate[p];
        end while (cnt < 200);
        @(posedge clk);
    endtask

    // discharge to soft start to run, with a fresh voltage code
    task automatic go_run();
        sense.voltage_id_code <= 5'($urandom % 31);
        sense.comp_above_release <= 1'b0;
        sense.comp_below_low <= 1'b1;
        tick(6);
        sense.comp_below_low <= 1'b0;
        sense.comp_above_release <= 1'b1;
        tick(6);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #500000;
        fail_count++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        sense = '0;
        sense.voltage_id_code = 5'h0a;
        sense.power_good_window_ok = 1'b1;
        k = $urandom(32'h22c8);
        tick(2);
        chk(ex(0, 0, 0, 1, 0, 0, 0));
        rst <= 1'b0;
        sense.module_on_input <= 1'b1;
        sense.comp_below_low <= 1'b1;
        tick(8);
        chk(ex(0, 0, 1, 1, 0, 0, 0));
        rreg(ADDR_STATE, 8'h00);
        rreg(ADDR_MASK, MASK_RESET);
        rreg(4'h2, 8'h00);
        wreg(4'h6, 8'hff);
        wreg(ADDR_CTRL, 8'ha4);
        rreg(ADDR_CTRL, 8'ha4);
        wreg(ADDR_CTRL, 8'h00);
        sense.supply_above_upper <= 1'b1;
        tick(6);
        chk(ex(0, 1, 1, 0, 1, 0, 0));
        rreg(ADDR_STATE, 8'h15);
        no_gate(3'h7);
        sense.comp_below_low <= 1'b0;
        sense.comp_above_release <= 1'b1;
        tick(6);
        rreg(ADDR_STATE, 8'h16);
        wait_rise(0, n);
        wait_rise(1, n);
        cmp(10'(PHASE_STEP_CYC), 10'(n));
        wait_rise(2, n);
        cmp(10'(PHASE_STEP_CYC), 10'(n));
        wait_rise(0, n);
        cmp(10'(OSC_PERIOD_CYC - 2 * PHASE_STEP_CYC), 10'(n));
        done("startup");

        k = $urandom % 3;
        wreg(ADDR_MASK, 8'h02);
        rreg(ADDR_MASK, 8'h02);
        sense.phase_limit <= 3'(1 << k);
        tick(6);
        chk(ex(1, 1, 1, 0, 0, 0, 1));
        no_gate(3'(1 << k));
        sense.phase_limit <= 3'h0;
        wait_rise(k, n);
        cmp(10'h1, {9'h0, n < 60});
        rreg(ADDR_STATUS, 8'h22);
        wreg(ADDR_MASK, 8'h00);
        chk(ex(1, 1, 1, 0, 0, 0, 0));
        wreg(ADDR_STATUS, 8'h22);
        wreg(ADDR_MASK, 8'h3f);
        rreg(ADDR_STATUS, 8'h00);
        chk(ex(1, 1, 1, 0, 0, 0, 0));
        wreg(ADDR_MASK, 8'h00);
        done("phase limit and interrupt");

        // the overcurrent must take exactly three edges to act
        sense.module_oc <= 1'b1;
        tick(2);
        chk(ex(1, 1, 1, 0, 0, 0, 0));
        chk(ex(0, 0, 1, 1, 0, 1, 0));
        rreg(ADDR_STATE, 8'h0c);
        sense.module_oc <= 1'b0;
        sense.comp_above_release <= 1'b0;
        sense.comp_below_low <= 1'b1;
        tick(6);
        chk(ex(0, 1, 1, 0, 1, 0, 0));
        rreg(ADDR_STATE, 8'h15);
        sense.comp_below_low <= 1'b0;
        sense.comp_above_release <= 1'b1;
        tick(6);
        rreg(ADDR_STATE, 8'h16);
        sense.module_oc <= 1'b1;
        tick(6);
        chk(ex(0, 0, 1, 1, 0, 1, 0));
        sense.module_oc <= 1'b0;
        done("hiccup");

        for (int m = 0; m < 4; m++) begin
            go_run();
            if (m == 0)
                sense.voltage_id_code <= VID_OFF_CODE;
            if (m == 1)
                sense.module_on_input <= 1'b0;
            if (m == 2)
                sense.supply_below_lower <= 1'b1;
            sense.supply_above_upper <= (m != 2);
            if (m == 3)
                wreg(ADDR_CTRL, 8'h01);
            tick(6);
            chk(ex(0, 0, m != 1, 1, 0, 0, 0));
            cmp(10'h0, {4'h0, hi_on, lo_on});
            sense.voltage_id_code <= 5'h05;
            sense.module_on_input <= 1'b1;
            sense.supply_below_lower <= 1'b0;
            sense.comp_above_release <= 1'b0;
            sense.comp_below_low <= 1'b1;
            if (m == 3)
                wreg(ADDR_CTRL, 8'h00);
            tick(6);
            chk(ex(0, m != 2, 1, m == 2, m != 2, 0, 0));
            sense.supply_above_upper <= 1'b1;
        end
        sense.comp_below_low <= 1'b0;
        rreg(ADDR_STATUS, 8'h3d);
        wreg(ADDR_STATUS, 8'hff);
        rreg(ADDR_STATUS, 8'h00);
        done("hold modes");
        give_verdict();
    end
endmodule
`default_nettype wire

// file: msf_sync.sv
// two-stage synchroniser for a bundle of comparator and pin levels
// assumes the inputs are levels; pulses shorter than a clock may be missed
`timescale 1ns/1ps
`default_nettype none
module msf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [1:0] warm_reg;

    // ------------------------------------------------------------------
    // two flops; only the second stage is read
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= i_d;  // [RQ11]
            stage2_reg <= stage1_reg;
        end
    end
    assign o_q = stage2_reg;

    // helper: marks when three edges have passed since reset
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            warm_reg <= 2'h0;
        end else if (warm_reg != 2'h3) begin
            warm_reg <= warm_reg + 2'h1;
        end
    end

    a_sync_two_stage: assert property ( // [RQ11]
        @(posedge i_core_clk) disable iff (i_rst)
        (warm_reg == 2'h3) |-> (o_q == $past(i_d, 2)))
        else $error("synchroniser output is not input delayed by two");
endmodule
`default_nettype wire
